// ### logic/bis_pkg.sv
// board interrupt subsystem: shared constants and types
// assumes a single 100 MHz clock domain and no software-reached registers
package bis_pkg;
	localparam int BIS_NUM_LVL = 8;
	localparam int BIS_LVL_W = 3;
	localparam int BIS_NUM_SRC = 16;
	localparam int BIS_SRC_FAILSAFE = 16;
	localparam int BIS_SRC_POWER = 17;
	localparam int BIS_NUM_CAND = 18;
	localparam int BIS_SEL_W = 5;
	localparam int BIS_VEC_BYTES_SHIFT = 2; // ip word then cs word per vector
	localparam logic [7:0] BIS_VEC_BASE = 8'h20; // type of level 0
	localparam logic [7:0] BIS_ISR_RST = 8'h00;
	localparam int BIS_CLK_HZ = 100000000;
	localparam int BIS_FAILSAFE_MS = 6;
	localparam int BIS_FAILSAFE_CYC = BIS_FAILSAFE_MS * (BIS_CLK_HZ / 1000);
	localparam int BIS_FS_CNT_W = 20;
	typedef logic [BIS_LVL_W-1:0] bis_lvl_t;
endpackage

// ### logic/bis_prio_if.sv
// carrier between the controller and its priority resolver
// assumes both ends sit on the same clock
`timescale 1ns/1ps
interface bis_prio_if;
	import bis_pkg::*;
	logic [BIS_NUM_LVL-1:0] req;
	logic [BIS_NUM_LVL-1:0] mask;
	logic [BIS_NUM_LVL-1:0] isr;
	logic grant_valid;
	bis_lvl_t grant_lvl;
	logic isr_any;
	bis_lvl_t isr_lvl;
	logic outranks;
	modport ctrl (output req, output mask, output isr, input grant_valid, input grant_lvl,
		input isr_any, input isr_lvl, input outranks);
	modport resolver (input req, input mask, input isr, output grant_valid, output grant_lvl,
		output isr_any, output isr_lvl, output outranks);
endinterface

// ### logic/bis_prio_resolve.sv
// priority resolver: picks the best unmasked request and the best level in service
// assumes level 0 is the highest priority; purely combinational
`timescale 1ns/1ps
module bis_prio_resolve (
	bis_prio_if.resolver p
);
	import bis_pkg::*;
	logic [BIS_NUM_LVL-1:0] pend;

	// masked levels never reach the comparison
	assign pend = p.req & ~p.mask;

	// scan from lowest priority upward so the highest one wins
	always_comb begin
		p.grant_valid = 1'b0;
		p.grant_lvl = '0;
		p.isr_any = 1'b0;
		p.isr_lvl = '0;
		for (int i = BIS_NUM_LVL - 1; i >= 0; i--) begin
			if (pend[i]) begin
				p.grant_valid = 1'b1;
				p.grant_lvl = bis_lvl_t'(i);
			end
			if (p.isr[i]) begin
				p.isr_any = 1'b1;
				p.isr_lvl = bis_lvl_t'(i);
			end
		end
	end

	// equal or lower requests wait for end of service
	assign p.outranks = p.grant_valid && (!p.isr_any || p.grant_lvl < p.isr_lvl);
endmodule

// ### logic/bis_top.sv
// board interrupt subsystem: request routing, failsafe timer, power-fail nmi,
// eight-level vectored priority controller with cascade hand-off.
// assumes every input comes from pins outside the clock domain; all are resynchronised.
// Function
// - nine levels, nmi wired straight, never maskable
// - controller vectors the eight lower levels
// - interrupt only when request outranks in-service
// - one mask byte blocks any level set
// - each level yields its own vector address
// - cascaded slaves supply vectors, up to 65
// - sixteen sources routed to inputs by jumper
// - two parallel interface requests, jumper routed
// - serial receive-ready and transmit-ready requests
// - each timer gives one jumper-routed request
// - two external lines routed by jumper
// - failsafe interrupt when bus access exceeds 6ms
// - power-fail request qualified by low-line warning
`timescale 1ns/1ps
module bis_top #(
	parameter int FAILSAFE_CYCLES = bis_pkg::BIS_FAILSAFE_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	// on-board request sources
	input wire logic [1:0] ppi_req,
	input wire logic uart_rx_ready,
	input wire logic uart_tx_ready,
	input wire logic [1:0] timer_req,
	input wire logic [7:0] bus_irq,
	input wire logic [1:0] ext_irq,
	// power fail
	input wire logic power_fail_req,
	input wire logic supply_line_low_warning,
	input wire logic nmi_power_jumper,
	// system bus access watch
	input wire logic bus_cycle_start,
	input wire logic bus_xack,
	// jumper routing, five bits per controller input
	input wire logic [bis_pkg::BIS_NUM_LVL*bis_pkg::BIS_SEL_W-1:0] route_sel,
	// processor side controls
	input wire logic [7:0] mask_byte,
	input wire logic inta,
	input wire logic eoi,
	input wire logic [7:0] cascade_en,
	input wire logic [7:0] slave_type,
	// processor side results
	output logic nmi,
	output logic intr,
	output logic [7:0] vector_type,
	output logic [9:0] vector_addr,
	output logic [2:0] cascade_level,
	output logic cascade_ack,
	output logic [7:0] in_service,
	output logic failsafe_flag
);
	import bis_pkg::*;
	localparam int PIN_W = 87;
	localparam int FS_LAST = FAILSAFE_CYCLES - 1;

	logic [PIN_W-1:0] pin_raw, sync_a_r, sync_b_r;
	logic [1:0] s_ppi, s_timer, s_ext;
	logic s_rx, s_tx, s_pf, s_low, s_jmp, s_start, s_xack, s_inta, s_eoi;
	logic [7:0] s_bus, s_mask, s_casc, s_slave;
	logic [BIS_NUM_LVL*BIS_SEL_W-1:0] s_route;
	logic inta_d_r, eoi_d_r, start_d_r;
	logic inta_p, eoi_p, start_p;
	logic [31:0] cand;
	logic [BIS_NUM_LVL-1:0] irr;
	logic [BIS_NUM_LVL-1:0] isr_r, isr_nxt;
	logic fs_busy_r, fs_flag_r;
	logic [BIS_FS_CNT_W-1:0] fs_cnt_r;
	logic [7:0] type_nxt;
	logic power_ok;
	bis_prio_if prio ();

	// every pin crosses two flops; stage a feeds only stage b
	assign pin_raw = {ppi_req, uart_rx_ready, uart_tx_ready, timer_req, bus_irq, ext_irq,
		power_fail_req, supply_line_low_warning, nmi_power_jumper, bus_cycle_start, bus_xack,
		route_sel, mask_byte, inta, eoi, cascade_en, slave_type};
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_a_r <= '0;
			sync_b_r <= '0;
		end else begin
			sync_a_r <= pin_raw;
			sync_b_r <= sync_a_r;
		end
	end
	assign {s_ppi, s_rx, s_tx, s_timer, s_bus, s_ext, s_pf, s_low, s_jmp, s_start, s_xack,
		s_route, s_mask, s_inta, s_eoi, s_casc, s_slave} = sync_b_r;

	// strobes from the processor are taken on their rising edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			inta_d_r <= 1'b0;
			eoi_d_r <= 1'b0;
			start_d_r <= 1'b0;
		end else begin
			inta_d_r <= s_inta;
			eoi_d_r <= s_eoi;
			start_d_r <= s_start;
		end
	end
	assign inta_p = s_inta & ~inta_d_r;
	assign eoi_p = s_eoi & ~eoi_d_r;
	assign start_p = s_start & ~start_d_r;

	// low-line warning qualifies the power-fail request
	assign power_ok = s_pf & s_low;

	// nmi bypasses the mask and the controller entirely
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nmi <= 1'b0;
		end else begin
			nmi <= power_ok & s_jmp;
		end
	end

	// failsafe: counts from access start until the slave acknowledges
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fs_busy_r <= 1'b0;
			fs_cnt_r <= '0;
		end else if (start_p) begin
			fs_busy_r <= 1'b1;
			fs_cnt_r <= '0;
		end else if (s_xack || (fs_busy_r && fs_cnt_r == BIS_FS_CNT_W'(FS_LAST))) begin
			fs_busy_r <= 1'b0;
		end else if (fs_busy_r) begin
			fs_cnt_r <= fs_cnt_r + 1'b1;
		end
	end

	// timeout flag holds until the next access; that clear wins over a timeout in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fs_flag_r <= 1'b0;
		end else if (fs_busy_r && !s_xack && !start_p && fs_cnt_r == BIS_FS_CNT_W'(FS_LAST)) begin
			fs_flag_r <= 1'b1;
		end else if (start_p) begin
			fs_flag_r <= 1'b0;
		end
	end
	assign failsafe_flag = fs_flag_r;

	// candidate sources: 0-1 parallel, 2 rx, 3 tx, 4-5 timers, 6-13 bus, 14-15 external
	assign cand = {14'h0, power_ok, fs_flag_r, s_ext, s_bus, s_timer, s_tx, s_rx, s_ppi};

	// each controller input picks one candidate; unused codes read as idle
	generate
		for (genvar g = 0; g < BIS_NUM_LVL; g++) begin : g_route
			assign irr[g] = cand[s_route[g*BIS_SEL_W +: BIS_SEL_W]];
		end
	endgenerate

	assign prio.req = irr;
	assign prio.mask = s_mask;
	assign prio.isr = isr_r;
	bis_prio_resolve u_resolve (
		.p(prio.resolver)
	);

	// request line follows the comparison; level requests keep it high until taken
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			intr <= 1'b0;
		end else begin
			intr <= prio.outranks;
		end
	end

	// in-service: end of service clears the top bit, acknowledge sets the granted one
	always_comb begin
		isr_nxt = isr_r;
		if (eoi_p && prio.isr_any) begin
			isr_nxt[prio.isr_lvl] = 1'b0;
		end
		if (inta_p && intr && prio.outranks) begin
			isr_nxt[prio.grant_lvl] = 1'b1; // set wins if both land together
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			isr_r <= BIS_ISR_RST;
		end else begin
			isr_r <= isr_nxt;
		end
	end
	assign in_service = isr_r;

	// a cascaded level takes its vector type from the slave on the bus
	always_comb begin
		if (s_casc[prio.grant_lvl]) begin
			type_nxt = s_slave;
		end else begin
			type_nxt = BIS_VEC_BASE + 8'(prio.grant_lvl);
		end
	end

	// vector is captured at acknowledge and held until the next one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vector_type <= 8'h00;
			vector_addr <= 10'h000;
			cascade_level <= 3'h0;
			cascade_ack <= 1'b0;
		end else begin
			cascade_ack <= 1'b0;
			if (inta_p && intr && prio.outranks) begin
				vector_type <= type_nxt;
				vector_addr <= {type_nxt, 2'b00};
				cascade_level <= prio.grant_lvl;
				cascade_ack <= s_casc[prio.grant_lvl];
			end
		end
	end
endmodule

// ### tb/bis_top_asserts.sv
// checker: pin timing of the interrupt subsystem
// assumes the top module's port names; bound below
`timescale 1ns/1ps
module bis_top_asserts
	import bis_pkg::*;
#(
	parameter int FAILSAFE_CYCLES = 20
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// inputs watched
	input wire logic power_fail_req,
	input wire logic supply_line_low_warning,
	input wire logic nmi_power_jumper,
	input wire logic bus_cycle_start,
	input wire logic [7:0] mask_byte,
	input wire logic inta,
	input wire logic eoi,
	// outputs watched
	input wire logic nmi,
	input wire logic intr,
	input wire logic [7:0] vector_type,
	input wire logic [9:0] vector_addr,
	input wire logic [2:0] cascade_level,
	input wire logic cascade_ack,
	input wire logic [7:0] in_service,
	input wire logic failsafe_flag
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// qualified power fail, tolerant of one cycle of sync slack
	wire pf_q = power_fail_req & supply_line_low_warning & nmi_power_jumper;
	nmi_follow_a: assert property ($past(pf_q, 3) == $past(pf_q, 4) |-> nmi == $past(pf_q, 4))
		else $error("nmi does not follow power fail");
	mask_block_a: assert property ((mask_byte == 8'hff) [*4] |=> !intr)
		else $error("intr under full mask");
	vec_addr_a: assert property (vector_addr == {vector_type, 2'b00})
		else $error("vector address wrong");
	vec_base_a: assert property ($changed(vector_type) && !cascade_ack |->
		vector_type == BIS_VEC_BASE + 8'(cascade_level))
		else $error("vector type wrong");
	ack_pulse_a: assert property (cascade_ack |=> !cascade_ack)
		else $error("cascade ack too long");
	isr_cause_a: assert property ($changed(in_service) |->
		$past(inta | eoi, 3) || $past(inta | eoi, 4))
		else $error("in service changed alone");
	top_isr_a: assert property (in_service[0] |=> !intr)
		else $error("intr over level 0");
	fs_clear_a: assert property ($rose(bus_cycle_start) |-> ##5 !failsafe_flag)
		else $error("failsafe not cleared");
endmodule
bind bis_top bis_top_asserts #(.FAILSAFE_CYCLES(FAILSAFE_CYCLES)) i_chk (.*);

// ### tb/bis_cpu_model.sv
// cpu model: acknowledges interrupts, ends service
// assumes the bench changes inputs after falling edges
`timescale 1ns/1ps
module bis_cpu_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// design side
	input wire logic intr,
	input wire logic [7:0] vector_type,
	output logic inta,
	output logic eoi,
	// bench side
	input wire logic auto_eoi,
	input wire logic eoi_req,
	output logic [7:0] got_type,
	output int n_ack
);
	// 3 high, 3 low: the spacing the sync stages need
	task strobe(input bit ack);
		if (ack) inta = 1;
		else eoi = 1;
		repeat (3) @(negedge clk);
		inta = 0;
		eoi = 0;
		repeat (3) @(negedge clk);
	endtask
	initial begin
		inta = 0;
		eoi = 0;
		got_type = 0;
		n_ack = 0;
		forever begin
			@(negedge clk);
			if (rst_n && intr) begin
				strobe(1);
				got_type = vector_type;
				n_ack++;
				if (auto_eoi) strobe(0);
			end else if (eoi_req) strobe(0);
		end
	end
endmodule

// ### tb/tb.sv
// bench: drives sources and jumpers, judges vectors via the cpu model
// assumes the failsafe count shortened to FS cycles
`timescale 1ns/1ps
module tb;
	import bis_pkg::*;
	localparam int FS = 20;
	logic clk = 0, rst_n = 0, pf = 0, low = 0, jmp = 0, bcs = 0, xack = 0, ae = 1, er = 0;
	logic [15:0] src = 0;
	logic [39:0] rsel = '1;
	logic [7:0] msk = 0, cen = 0, sty = 0, vt, isr, gt;
	logic nmi, intr, inta, eoi, fsf, cack;
	logic [9:0] va;
	logic [2:0] cl;
	int n_ack, k, n_errors = 0, checks = 0, n_cack = 0;
	always #5 clk = ~clk;
	bis_top #(.FAILSAFE_CYCLES(FS)) i_dut (.clk(clk), .rst_n(rst_n), .ppi_req(src[1:0]),
		.uart_rx_ready(src[2]), .uart_tx_ready(src[3]), .timer_req(src[5:4]),
		.bus_irq(src[13:6]), .ext_irq(src[15:14]), .power_fail_req(pf),
		.supply_line_low_warning(low), .nmi_power_jumper(jmp), .bus_cycle_start(bcs),
		.bus_xack(xack), .route_sel(rsel), .mask_byte(msk), .inta(inta), .eoi(eoi),
		.cascade_en(cen), .slave_type(sty), .nmi(nmi), .intr(intr), .vector_type(vt),
		.vector_addr(va), .cascade_level(cl), .cascade_ack(cack), .in_service(isr),
		.failsafe_flag(fsf));
	bis_cpu_model i_cpu (.clk(clk), .rst_n(rst_n), .intr(intr), .vector_type(vt),
		.inta(inta), .eoi(eoi), .auto_eoi(ae), .eoi_req(er), .got_type(gt), .n_ack(n_ack));
	// the cascade pulse lasts one cycle, so mid-cycle sampling counts each exactly once
	always @(negedge clk) begin
		if (cack === 1'b1) n_cack++;
	end
	task cmp(input logic [31:0] got, exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("checks=%0d mismatches=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task route(input int lvl, c);
		rsel[lvl*5+:5] = 5'(c);
	endtask
	// request dropped before service ends, so no second acknowledge
	task req(input int c);
		src[c] = 1;
		cyc(8);
		src[c] = 0;
		cyc(16);
	endtask
	task eoi_pulse;
		er = 1;
		cyc(4);
		er = 0;
		cyc(10);
	endtask
	task t_sources;
		for (int c = 0; c < 16; c++) begin
			k = n_ack;
			route(c % 8, c);
			req(c);
			cmp(gt, BIS_VEC_BASE + 8'(c % 8));
			cmp(n_ack, k + 1);
			route(c % 8, 31);
		end
		cmp(n_cack, 0);
		$display("sources done");
	endtask
	// nested service, then a lower level held off until both end
	task t_prio;
		ae = 0;
		route(5, 7);
		route(2, 6);
		route(6, 8);
		src[7] = 1;
		cyc(14);
		src[6] = 1;
		cyc(14);
		cmp(isr, 8'h24);
		cmp(gt, 8'h22);
		src[8] = 1;
		src[7:6] = 0;
		k = n_ack;
		cyc(14);
		eoi_pulse();
		cmp(isr, 8'h20);
		cmp(n_ack, k);
		eoi_pulse();
		cyc(6);
		cmp(isr, 8'h40);
		src[8] = 0;
		eoi_pulse();
		cmp(isr, 0);
		ae = 1;
		rsel = '1;
		$display("prio done");
	endtask
	task t_mask;
		k = n_ack;
		msk = 8'h08;
		route(3, 3);
		src[3] = 1;
		cyc(14);
		cmp(n_ack, k);
		msk = 0;
		req(3);
		cmp(gt, 8'h23);
		route(3, 31);
		$display("mask done");
	endtask
	task t_nmi;
		msk = 8'hff;
		for (int i = 0; i < 8; i++) begin
			{pf, low, jmp} = 3'(i);
			cyc(6);
			cmp(nmi, i == 7);
		end
		{pf, low, jmp} = 0;
		msk = 0;
		// qualified power fail routed into the controller instead of the nmi line
		k = n_ack;
		route(7, 17);
		{pf, low, jmp} = 3'b110;
		cyc(8);
		cmp(nmi, 0);
		{pf, low, jmp} = 3'b000;
		cyc(16);
		cmp(gt, 8'h27);
		cmp(n_ack, k + 1);
		route(7, 31);
		$display("nmi done");
	endtask
	task t_fs;
		route(1, 16);
		bcs = 1;
		cyc(FS);
		cmp(fsf, 0);
		cyc(20);
		cmp(fsf, 1);
		cmp(gt, 8'h21);
		route(1, 31);
		bcs = 0;
		cyc(4);
		xack = 1;
		bcs = 1;
		cyc(FS + 12);
		cmp(fsf, 0);
		bcs = 0;
		xack = 0;
		$display("failsafe done");
	endtask
	task t_casc;
		k = n_cack;
		cen = 8'h10;
		sty = 8'h9c;
		route(4, 4);
		req(4);
		cmp(gt, 8'h9c);
		cmp(va, 10'h270);
		cmp(cl, 3'h4);
		cmp(n_cack, k + 1);
		route(4, 31);
		$display("cascade done");
	endtask
	initial begin
		cyc(8);
		rst_n = 1;
		cyc(4);
		t_sources();
		t_prio();
		t_mask();
		t_nmi();
		t_fs();
		t_casc();
		stop_test();
	end
	// tests need under 1000 cycles; allow about twice that
	initial begin
		#20000;
		n_errors++;
		stop_test();
	end
endmodule
